//--- logic/idc_pkg.sv
package idc_pkg;
	// instruction word layout
	localparam int IDC_WORD_W     = 32;
	localparam int IDC_OPC_HI     = 31;
	localparam int IDC_OPC_LO     = 26;
	localparam int IDC_SRC_HI     = 25;
	localparam int IDC_SRC_LO     = 21;
	localparam int IDC_TGT_HI     = 20;
	localparam int IDC_TGT_LO     = 16;
	localparam int IDC_DST_HI     = 15;
	localparam int IDC_DST_LO     = 11;
	localparam int IDC_SHAMT_HI   = 10;
	localparam int IDC_SHAMT_LO   = 6;
	localparam int IDC_FUNC_HI    = 5;
	localparam int IDC_FUNC_LO    = 0;
	localparam int IDC_IMM_HI     = 15;
	localparam int IDC_INDEX_HI   = 25;
	localparam int IDC_JUMP_SHIFT = 2;
	localparam int IDC_JUMP_W     = 28;
	localparam int IDC_NUM_CP     = 4;
	localparam int IDC_CP_REGS    = 32;
	// primary opcodes
	localparam logic [5:0] IDC_OPC_SPECIAL  = 6'h00;
	localparam logic [5:0] IDC_OPC_REG_IMMEDIATE_CLASS = 6'h01;
	localparam logic [5:0] IDC_OPC_J        = 6'h02;
	localparam logic [5:0] IDC_OPC_JAL      = 6'h03;
	localparam logic [5:0] IDC_OPC_SYSCTL   = 6'h10;
	localparam logic [5:0] IDC_OPC_COP1     = 6'h11;
	localparam logic [5:0] IDC_OPC_COP2     = 6'h12;
	localparam logic [5:0] IDC_OPC_FPU_EXTENDED_SPACE = 6'h13;
	localparam logic [5:0] IDC_OPC_LWC1     = 6'h31;
	localparam logic [5:0] IDC_OPC_LWC2     = 6'h32;
	localparam logic [5:0] IDC_OPC_LDC1     = 6'h35;
	localparam logic [5:0] IDC_OPC_LDC2     = 6'h36;
	localparam logic [5:0] IDC_OPC_SWC1     = 6'h39;
	localparam logic [5:0] IDC_OPC_SWC2     = 6'h3a;
	localparam logic [5:0] IDC_OPC_SDC1     = 6'h3d;
	localparam logic [5:0] IDC_OPC_SDC2     = 6'h3e;
	// coprocessor sub-op in source field: move-from / move-to
	localparam logic [4:0] IDC_CSUB_MF      = 5'h00;
	localparam logic [4:0] IDC_CSUB_DMF     = 5'h01;
	localparam logic [4:0] IDC_CSUB_CF      = 5'h02;
	localparam logic [4:0] IDC_CSUB_MT      = 5'h04;
	localparam logic [4:0] IDC_CSUB_DMT     = 5'h05;
	localparam logic [4:0] IDC_CSUB_CT      = 5'h06;
	// extended space: fused multiply-add functions 0x20..0x3f, reciprocal funcs in cop1
	localparam logic [5:0] IDC_FN_RECIP     = 6'h15;
	localparam logic [5:0] IDC_FN_RSQRT     = 6'h16;
	localparam logic       IDC_FRSEL_RST    = 1'b0;
	localparam logic       IDC_EN_RST       = 1'b0;

	typedef enum logic [1:0] {IDC_CP_SYS, IDC_CP_FPU, IDC_CP_CUSTOM, IDC_CP_FPU_AUX} idc_slot_t;
	typedef enum logic [1:0] {IDC_FMT_IMM, IDC_FMT_JUMP, IDC_FMT_REG} idc_fmt_t;
	typedef enum logic [1:0] {IDC_CK_NONE, IDC_CK_MOVE, IDC_CK_MEM, IDC_CK_COMPUTE} idc_ckind_t;
endpackage : idc_pkg

//--- logic/idc_fields.sv
module idc_fields
	import idc_pkg::*;
(
	input  wire logic [IDC_WORD_W-1:0] i_word,        // raw instruction
	output logic      [5:0]            o_opcode,      // primary opcode
	output logic      [4:0]            o_src,         // source selector
	output logic      [4:0]            o_tgt,         // target selector
	output logic      [4:0]            o_dst,         // destination selector
	output logic      [4:0]            o_shamt,       // shift amount
	output logic      [5:0]            o_func,        // function code
	output logic      [31:0]           o_imm_sext,    // sign-extended immediate
	output logic      [IDC_JUMP_W-1:0] o_jump_low     // low jump target bits
);
	// fixed field slicing
	assign o_opcode   = i_word[IDC_OPC_HI:IDC_OPC_LO];
	assign o_src      = i_word[IDC_SRC_HI:IDC_SRC_LO];
	assign o_tgt      = i_word[IDC_TGT_HI:IDC_TGT_LO];
	assign o_dst      = i_word[IDC_DST_HI:IDC_DST_LO];
	assign o_shamt    = i_word[IDC_SHAMT_HI:IDC_SHAMT_LO];
	assign o_func     = i_word[IDC_FUNC_HI:IDC_FUNC_LO];
	assign o_imm_sext = {{16{i_word[IDC_IMM_HI]}}, i_word[IDC_IMM_HI:0]};
	assign o_jump_low = {i_word[IDC_INDEX_HI:0], 2'b00};
endmodule // idc_fields

//--- logic/idc_cp_route.sv
module idc_cp_route
	import idc_pkg::*;
(
	input  wire logic [5:0]            i_opcode,      // primary opcode
	input  wire logic [4:0]            i_src,         // sub-op field
	input  wire logic                  i_ext_space,   // later release flag
	output logic                       o_is_cp,       // coprocessor class
	output idc_pkg::idc_slot_t         o_slot,        // target slot
	output idc_pkg::idc_ckind_t        o_kind,        // kind of operation
	output logic                       o_is_fpu       // floating point op
);
	// decode class per opcode
	wire w_sys   = (i_opcode == IDC_OPC_SYSCTL);
	wire w_cop1  = (i_opcode == IDC_OPC_COP1);
	wire w_cop2  = (i_opcode == IDC_OPC_COP2);
	wire w_cop3  = (i_opcode == IDC_OPC_FPU_EXTENDED_SPACE);
	wire w_mem1  = (i_opcode == IDC_OPC_LWC1) || (i_opcode == IDC_OPC_LDC1) ||
	               (i_opcode == IDC_OPC_SWC1) || (i_opcode == IDC_OPC_SDC1);
	wire w_mem2  = (i_opcode == IDC_OPC_LWC2) || (i_opcode == IDC_OPC_LDC2) ||
	               (i_opcode == IDC_OPC_SWC2) || (i_opcode == IDC_OPC_SDC2);
	wire w_move  = (i_src == IDC_CSUB_MF) || (i_src == IDC_CSUB_DMF) || (i_src == IDC_CSUB_CF) ||
	               (i_src == IDC_CSUB_MT) || (i_src == IDC_CSUB_DMT) || (i_src == IDC_CSUB_CT);
	// no memory form exists for slot 0, so it never appears here
	assign o_is_cp  = w_sys || w_cop1 || w_cop2 || w_cop3 || w_mem1 || w_mem2;
	assign o_slot   = (w_sys) ? IDC_CP_SYS :
	                  (w_cop1 || w_mem1 || (w_cop3 && i_ext_space)) ? IDC_CP_FPU :
	                  (w_cop3) ? IDC_CP_FPU_AUX : IDC_CP_CUSTOM;
	assign o_kind   = (!o_is_cp) ? IDC_CK_NONE :
	                  (w_mem1 || w_mem2) ? IDC_CK_MEM :
	                  (w_cop3) ? IDC_CK_COMPUTE :
	                  (w_move) ? IDC_CK_MOVE : IDC_CK_COMPUTE;
	assign o_is_fpu = w_cop1 || w_mem1 || w_cop3;
endmodule // idc_cp_route

//--- logic/idc_decoder.sv
// Operation
// - each instruction is one 32-bit word from a word-aligned address
// - primary opcode is bits 31..26
// - source selector is bits 25..21
// - target selector bits 20..16, also picks reg-immediate class operation
// - register format destination selector is bits 15..11
// - register format shift amount bits 10..6, function bits 5..0
// - 16-bit immediate is signed, sign-extended for all uses
// - jump index shifted left two gives low 28 target bits
// - 32-bit integer ops need sign-extended operands; flagged otherwise for register-format non-shift ops only
// - at most four coprocessor slots numbered 0 to 3
// - slot 0 is system control; slots 1 and 3 are floating point
// - slot 2 is free for implementation use
// - each coprocessor register set holds up to 32 registers
// - computational ops may address general or control set; here only moves (CF, CT) select the control set
// - system control has no loads or stores, only moves; here non-move sub-ops on slot 0 are dispatched as compute
// - coprocessor load, store, move are in main opcode space
// - later releases route slot 3 compute space to floating point
// - floating point enable is privileged, set via system control
// - floating point op while disabled raises unusable exception
// - register-width mode bit selects 32 or 64-bit float model
// - 32-bit binaries execute unmodified
// - multiply-add and reciprocal ops are flagged as non-standard precision
module idc_decoder
	import idc_pkg::*;
#(
	parameter int NUM_CP = IDC_NUM_CP        // coprocessor slots
)(
	input  wire logic                    i_clk,             // core clock
	input  wire logic                    i_arst_n,          // async reset, low
	input  wire logic                    i_valid,           // instruction valid
	input  wire logic [IDC_WORD_W-1:0]   i_word,            // instruction word
	input  wire logic [63:0]             i_pc,              // fetch address
	input  wire logic                    i_kernel,          // privileged mode
	input  wire logic                    i_ext_space,       // later release mode
	input  wire logic [63:0]             i_src_val,         // source operand
	input  wire logic [63:0]             i_tgt_val,         // target operand
	input  wire logic                    i_fpu_en_wr,       // sysctl enable write
	input  wire logic                    i_fpu_en_val,      // enable value
	input  wire logic                    i_frsel_wr,        // width mode write
	input  wire logic                    i_frsel_val,       // width mode value
	input  wire logic [NUM_CP-1:0]       i_cp_ready,        // slot ready
	output logic                         o_ready,           // accepts word
	output logic                         o_valid,           // decoded valid
	output logic      [5:0]              o_opcode,          // primary opcode
	output logic      [4:0]              o_source_reg_field, // source sel
	output logic      [4:0]              o_target_reg_field, // target sel
	output logic      [4:0]              o_dst_reg_field,   // dest sel
	output logic      [4:0]              o_shift_amount_field, // shift amount
	output logic      [5:0]              o_func,            // function code
	output logic      [31:0]             o_imm,             // sign-ext imm
	output logic      [63:0]             o_jump_target,     // jump target
	output idc_pkg::idc_fmt_t            o_fmt,             // format
	output logic                         o_reg_immediate_class, // reg_immediate_class op
	output logic                         o_operand_undef,   // undefined operands
	output logic      [NUM_CP-1:0]       o_cp_dispatch,     // slot strobe
	output idc_pkg::idc_ckind_t          o_cp_kind,         // op kind
	output logic                         o_cp_ctrl_set,     // control reg set
	output logic                         o_cp_unusable,     // exception pulse
	output logic      [1:0]              o_cp_unusable_num, // failing slot
	output logic                         o_align_err,       // misaligned fetch
	output logic                         o_nonstd_prec,     // non-standard precision
	output logic                         o_fpu_en,          // enable state
	output logic                         o_fpu_reg_width_select // 64-bit model
);
	////////////////////////////////////////////////////////////////////////////
	// field extraction
	logic [5:0]            w_opc;
	logic [4:0]            w_src;
	logic [4:0]            w_tgt;
	logic [4:0]            w_dst;
	logic [4:0]            w_sh;
	logic [5:0]            w_fn;
	logic [31:0]           w_imm;
	logic [IDC_JUMP_W-1:0] w_jlow;
	logic                  w_is_cp;
	idc_slot_t             w_slot;
	idc_ckind_t            w_kind;
	logic                  w_is_fpu;

	idc_fields u_fields (
		.i_word     (i_word),
		.o_opcode   (w_opc),
		.o_src      (w_src),
		.o_tgt      (w_tgt),
		.o_dst      (w_dst),
		.o_shamt    (w_sh),
		.o_func     (w_fn),
		.o_imm_sext (w_imm),
		.o_jump_low (w_jlow)
	);

	idc_cp_route u_route (
		.i_opcode    (w_opc),
		.i_src       (w_src),
		.i_ext_space (i_ext_space),
		.o_is_cp     (w_is_cp),
		.o_slot      (w_slot),
		.o_kind      (w_kind),
		.o_is_fpu    (w_is_fpu)
	);

	////////////////////////////////////////////////////////////////////////////
	// enable and width mode state
	logic fpu_en_q;
	logic frsel_q;
	// only privileged writes through the system control path take effect
	wire  w_en_take = i_fpu_en_wr && i_kernel;
	wire  w_fr_take = i_frsel_wr && i_kernel;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			fpu_en_q <= IDC_EN_RST;
			frsel_q  <= IDC_FRSEL_RST;
		end else begin
			if (w_en_take) fpu_en_q <= i_fpu_en_val;
			if (w_fr_take) frsel_q <= i_frsel_val;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// combinational classification
	wire w_fmt_jump = (w_opc == IDC_OPC_J) || (w_opc == IDC_OPC_JAL);
	wire w_fmt_reg  = (w_opc == IDC_OPC_SPECIAL);
	idc_fmt_t w_fmt;
	assign w_fmt = w_fmt_jump ? IDC_FMT_JUMP : (w_fmt_reg ? IDC_FMT_REG : IDC_FMT_IMM);
	// word alignment of the fetch address
	wire w_misalign = (i_pc[1:0] != 2'b00);
	// a 64-bit value is a proper 32-bit integer when upper half mirrors bit 31
	wire w_src_ok = (i_src_val[63:32] == {32{i_src_val[31]}});
	wire w_tgt_ok = (i_tgt_val[63:32] == {32{i_tgt_val[31]}});
	// shifts take raw values; other special ops need clean operands
	wire w_is_shift = w_fmt_reg && (w_fn[5:3] == 3'b000);
	wire w_undef    = (w_fmt_reg && !w_is_shift) && !(w_src_ok && w_tgt_ok);
	// floating point needs slot 1 enabled, whatever slot carries it
	wire w_unusable = w_is_cp && w_is_fpu && !fpu_en_q;
	// slot 0 needs privilege, else unusable as well
	wire w_sys_unusable = w_is_cp && (w_slot == IDC_CP_SYS) && !i_kernel;
	wire w_trap     = w_unusable || w_sys_unusable;
	wire [1:0] w_slot_idx = 2'(w_slot);
	// extended space multiply-add (funcs 0x20..0x3f) and reciprocal roots
	wire w_nonstd = w_is_cp && w_is_fpu &&
	                (((w_opc == IDC_OPC_FPU_EXTENDED_SPACE) && w_fn[5]) ||
	                 ((w_opc == IDC_OPC_COP1) && ((w_fn == IDC_FN_RECIP) || (w_fn == IDC_FN_RSQRT))));
	// move ops pick control set through sub-op CF or CT (bit 1 of source sub-op); computational ops use general set
	wire w_ctrl_set = (w_kind == IDC_CK_MOVE) ? ((w_src == IDC_CSUB_CF) || (w_src == IDC_CSUB_CT)) : 1'b0;
	// the selected slot must be ready to accept
	wire w_slot_rdy = !w_is_cp || w_trap || i_cp_ready[w_slot_idx];
	wire w_take     = i_valid && w_slot_rdy;
	assign o_ready  = w_slot_rdy;
	wire [63:0] w_jtarget = {i_pc[63:IDC_JUMP_W], w_jlow};

	////////////////////////////////////////////////////////////////////////////
	// registered decode outputs
	logic                valid_q;
	logic [5:0]          opc_q;
	logic [4:0]          src_q;
	logic [4:0]          tgt_q;
	logic [4:0]          dst_q;
	logic [4:0]          sh_q;
	logic [5:0]          fn_q;
	logic [31:0]         imm_q;
	logic [63:0]         jt_q;
	idc_fmt_t            fmt_q;
	logic                reg_imm_class_q;
	logic                undef_q;
	logic [NUM_CP-1:0]   disp_q;
	idc_ckind_t          kind_q;
	logic                ctrl_q;
	logic                unus_q;
	logic [1:0]          unus_num_q;
	logic                align_q;
	logic                nonstd_q;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			valid_q    <= 1'b0;
			opc_q      <= 6'h00;
			src_q      <= 5'h00;
			tgt_q      <= 5'h00;
			dst_q      <= 5'h00;
			sh_q       <= 5'h00;
			fn_q       <= 6'h00;
			imm_q      <= 32'h0000_0000;
			jt_q       <= 64'h0;
			fmt_q      <= IDC_FMT_IMM;
			reg_imm_class_q <= 1'b0;
			undef_q    <= 1'b0;
			kind_q     <= IDC_CK_NONE;
			ctrl_q     <= 1'b0;
			unus_q     <= 1'b0;
			unus_num_q <= 2'h0;
			align_q    <= 1'b0;
			nonstd_q   <= 1'b0;
		end else begin
			valid_q    <= w_take && !w_misalign;
			align_q    <= w_take && w_misalign;
			opc_q      <= w_opc;
			src_q      <= w_src;
			tgt_q      <= w_tgt;
			dst_q      <= w_dst;
			sh_q       <= w_sh;
			fn_q       <= w_fn;
			imm_q      <= w_imm;
			jt_q       <= w_jtarget;
			fmt_q      <= w_fmt;
			reg_imm_class_q <= (w_opc == IDC_OPC_REG_IMMEDIATE_CLASS);
			undef_q    <= w_take && w_undef;
			kind_q     <= w_kind;
			ctrl_q     <= w_ctrl_set;
			unus_q     <= w_take && !w_misalign && w_trap;
			unus_num_q <= w_unusable ? 2'h1 : w_slot_idx;
			nonstd_q   <= w_take && w_nonstd;
		end
	end

	// one dispatch strobe per slot, held off on a trap
	for (genvar g = 0; g < NUM_CP; g++) begin : g_disp
		always_ff @(posedge i_clk or negedge i_arst_n) begin
			if (!i_arst_n) disp_q[g] <= 1'b0;
			else disp_q[g] <= w_take && !w_misalign && w_is_cp && !w_trap && (w_slot_idx == g);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// output drive
	assign o_valid                = valid_q;
	assign o_opcode               = opc_q;
	assign o_source_reg_field     = src_q;
	assign o_target_reg_field     = tgt_q;
	assign o_dst_reg_field        = dst_q;
	assign o_shift_amount_field   = sh_q;
	assign o_func                 = fn_q;
	assign o_imm                  = imm_q;
	assign o_jump_target          = jt_q;
	assign o_fmt                  = fmt_q;
	assign o_reg_immediate_class  = reg_imm_class_q;
	assign o_operand_undef        = undef_q;
	assign o_cp_dispatch          = disp_q;
	assign o_cp_kind              = kind_q;
	assign o_cp_ctrl_set          = ctrl_q;
	assign o_cp_unusable          = unus_q;
	assign o_cp_unusable_num      = unus_num_q;
	assign o_align_err            = align_q;
	assign o_nonstd_prec          = nonstd_q;
	assign o_fpu_en               = fpu_en_q;
	assign o_fpu_reg_width_select = frsel_q;

	////////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_fp_issue_disabled;
		i_valid && w_is_fpu && w_is_cp && !fpu_en_q && !w_misalign;
	endsequence

	AST_FP_DISABLED_TRAPS: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		s_fp_issue_disabled |=> o_cp_unusable && (o_cp_dispatch == '0) && (o_cp_unusable_num == 2'h1))
		else $error("disabled float op not trapped");

	AST_OPCODE_FIELD: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		1'b1 |=> o_opcode == $past(i_word[31:26]))
		else $error("opcode field wrong");

	AST_SRC_TGT_FIELDS: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		1'b1 |=> (o_source_reg_field == $past(i_word[25:21])) && (o_target_reg_field == $past(i_word[20:16])))
		else $error("source or target field wrong");

	AST_IMM_SIGNED: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		i_word[15] |=> o_imm[31:16] == 16'hffff)
		else $error("immediate not sign-extended");

	AST_JUMP_TARGET: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		1'b1 |=> (o_jump_target[27:0] == {$past(i_word[25:0]), 2'b00}))
		else $error("jump target low bits wrong");

	AST_MISALIGN: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(i_valid && o_ready && (i_pc[1:0] != 2'b00)) |=> o_align_err && !o_valid && (o_cp_dispatch == '0))
		else $error("misaligned word accepted");

	AST_ENABLE_PRIV: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(i_fpu_en_wr && !i_kernel) |=> $stable(o_fpu_en))
		else $error("unprivileged enable write took effect");

	AST_SLOT0_SYS: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(i_valid && i_kernel && (i_word[31:26] == IDC_OPC_SYSCTL) && (i_pc[1:0] == 2'b00) && o_ready)
		|=> o_cp_dispatch[0] && o_valid)
		else $error("sysctl op not dispatched to slot 0");

	AST_ONEHOT_DISPATCH: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		$onehot0(o_cp_dispatch) && !(o_cp_unusable && (o_cp_dispatch != '0)))
		else $error("dispatch not one-hot or traps and dispatches");

	AST_WIDTH_MODE: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(i_frsel_wr && i_kernel) |=> o_fpu_reg_width_select == $past(i_frsel_val))
		else $error("width mode write lost");

	AST_UNDEF_OPERAND: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(i_valid && o_ready && (i_word[31:26] == IDC_OPC_SPECIAL) && (i_word[5:3] != 3'b000)
		 && (i_src_val[63:32] != {32{i_src_val[31]}})) |=> o_operand_undef)
		else $error("bad operand not flagged");

	AST_FIELDS_REG: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		1'b1 |=> (o_dst_reg_field == $past(i_word[15:11])) && (o_shift_amount_field == $past(i_word[10:6]))
		&& (o_func == $past(i_word[5:0])))
		else $error("register format fields wrong");

	// one aligned accepted word of a given opcode, plus a side condition
	sequence s_clean_issue(logic [5:0] opc, logic cond);
		i_valid && o_ready && (i_word[31:26] == opc) && (i_pc[1:0] == 2'b00) && cond;
	endsequence

	AST_SLOT_FPU_EXT: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		s_clean_issue(IDC_OPC_FPU_EXTENDED_SPACE, i_ext_space && fpu_en_q) |=> o_cp_dispatch[1])
		else $error("extended space not sent to float slot");

	AST_SLOT_FPU_AUX: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		s_clean_issue(IDC_OPC_FPU_EXTENDED_SPACE, !i_ext_space && fpu_en_q) |=> o_cp_dispatch[3])
		else $error("slot 3 op not dispatched");

	AST_SLOT_CUSTOM: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		s_clean_issue(IDC_OPC_COP2, 1'b1) |=> o_cp_dispatch[2] && o_valid)
		else $error("custom slot op not dispatched");

	AST_SYS_NO_MEM: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		o_cp_dispatch[0] |-> (o_cp_kind != IDC_CK_MEM))
		else $error("memory op reached system control");

	AST_MEM_KIND: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		s_clean_issue(IDC_OPC_LWC1, 1'b1) |=> (o_cp_kind == IDC_CK_MEM))
		else $error("coprocessor load not marked memory");

	AST_NONSTD: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		s_clean_issue(IDC_OPC_FPU_EXTENDED_SPACE, i_word[5]) |=> o_nonstd_prec)
		else $error("multiply-add not flagged");

	AST_ENABLE_TAKE: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(i_fpu_en_wr && i_kernel) |=> (o_fpu_en == $past(i_fpu_en_val)))
		else $error("privileged enable write lost");

	AST_WIDTH_HOLD: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		!(i_frsel_wr && i_kernel) |=> $stable(o_fpu_reg_width_select))
		else $error("width mode changed without write");
endmodule // idc_decoder

//--- verification/idc_cp_model.sv
module idc_cp_model
	import idc_pkg::*;
(
	input  wire logic [IDC_NUM_CP-1:0] i_stall,    // slots told to stall
	output logic      [IDC_NUM_CP-1:0] o_cp_ready  // ready per slot
);
	timeunit 1ns;
	timeprecision 1ps;
	// four slots answer ready at once unless the bench stalls them
	assign o_cp_ready = ~i_stall;
endmodule // idc_cp_model

//--- verification/cpu_instr_decode_coproc_dispatch_bench.sv
module cpu_instr_decode_coproc_dispatch_bench;
	import idc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_clk, i_arst_n, i_valid, i_kernel, i_ext_space, i_fpu_en_wr, i_fpu_en_val, i_frsel_wr, i_frsel_val;
	logic [31:0] i_word, w;
	logic [63:0] i_pc, i_src_val, i_tgt_val, p, src_v, o_jump_target;
	logic [3:0]  i_cp_ready, stall, o_cp_dispatch;
	logic [5:0]  opc, o_opcode, o_func;
	logic [4:0]  o_src, o_tgt, o_dst, o_sh;
	logic [31:0] o_imm;
	logic [1:0]  o_unum;
	logic        o_ready, o_valid, o_reg_imm_cls, o_undef, o_ctrl, o_unus, o_align, o_nonstd, o_fpu_en, o_width;
	idc_fmt_t    o_fmt;
	idc_ckind_t  o_cp_kind;
	int          n_mismatch = 0;
	int          cmp_count = 0;
	////////////////////////////////////////////////////////////////
	// design and far-side model
	idc_decoder dut_u (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_valid(i_valid), .i_word(i_word), .i_pc(i_pc),
		.i_kernel(i_kernel), .i_ext_space(i_ext_space), .i_src_val(i_src_val), .i_tgt_val(i_tgt_val),
		.i_fpu_en_wr(i_fpu_en_wr), .i_fpu_en_val(i_fpu_en_val), .i_frsel_wr(i_frsel_wr), .i_frsel_val(i_frsel_val),
		.i_cp_ready(i_cp_ready), .o_ready(o_ready), .o_valid(o_valid), .o_opcode(o_opcode),
		.o_source_reg_field(o_src), .o_target_reg_field(o_tgt), .o_dst_reg_field(o_dst),
		.o_shift_amount_field(o_sh), .o_func(o_func), .o_imm(o_imm), .o_jump_target(o_jump_target), .o_fmt(o_fmt),
		.o_reg_immediate_class(o_reg_imm_cls), .o_operand_undef(o_undef), .o_cp_dispatch(o_cp_dispatch),
		.o_cp_kind(o_cp_kind), .o_cp_ctrl_set(o_ctrl), .o_cp_unusable(o_unus), .o_cp_unusable_num(o_unum),
		.o_align_err(o_align), .o_nonstd_prec(o_nonstd), .o_fpu_en(o_fpu_en), .o_fpu_reg_width_select(o_width));
	idc_cp_model cp_u (.i_stall(stall), .o_cp_ready(i_cp_ready));
	////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic [31:0] mk(input logic [5:0] op, input logic [4:0] sub, input logic [5:0] fn);
		return {op, sub, 15'h0, fn};
	endfunction
	function automatic idc_fmt_t fmt_exp(input logic [5:0] op);
		if (op == IDC_OPC_SPECIAL) return IDC_FMT_REG;
		if (op == IDC_OPC_J || op == IDC_OPC_JAL) return IDC_FMT_JUMP;
		return IDC_FMT_IMM;
	endfunction
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic finish_test();
		if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// present one word, check after the taking edge has landed
	task automatic step(input logic [31:0] wd, input logic [63:0] pc, input logic k);
		@(posedge i_clk);
		i_word <= wd;
		i_pc <= pc;
		i_kernel <= k;
		i_valid <= 1'b1;
		i_src_val <= src_v;
		i_tgt_val <= 64'($signed($urandom()));
		@(posedge i_clk);
		#1;
	endtask
	task automatic cop(input logic [31:0] wd, input logic k, input logic [3:0] d, input logic u);
		step(wd, 64'h0, k);
		chk("valid", o_valid, 1'b1);
		chk("dispatch", o_cp_dispatch, d);
		chk("unusable", o_unus, u);
	endtask
	// one-cycle write, privileged when k is set, of enable (sel 0) or width mode (sel 1)
	task automatic wr(input logic k, input logic sel, input logic v);
		@(posedge i_clk);
		i_valid <= 1'b0;
		i_kernel <= k;
		i_fpu_en_wr <= ~sel;
		i_frsel_wr <= sel;
		i_fpu_en_val <= v;
		i_frsel_val <= v;
		@(posedge i_clk);
		i_fpu_en_wr <= 1'b0;
		i_frsel_wr <= 1'b0;
		@(posedge i_clk);
		#1;
	endtask
	////////////////////////////////////////////////////////////////
	// clock, watchdog, main sequence
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	initial begin
		repeat (2000) @(posedge i_clk);
		n_mismatch++;
		finish_test();
	end
	initial begin
		{i_arst_n, i_valid, i_fpu_en_wr, i_fpu_en_val, i_frsel_wr, i_frsel_val} = '0;
		{i_word, i_pc, i_src_val, i_tgt_val, stall, src_v} = '0;
		i_kernel = 1'b1;
		i_ext_space = 1'b1;
		void'($urandom(32'h75c026f6));
		repeat (16) @(posedge i_clk);
		i_arst_n <= 1'b1;
		for (int k = 0; k < 40; k++) begin
			opc = 6'($urandom_range(0, 15));
			if (opc > 6'h03) opc = opc + 6'h1c;
			w = {opc, 26'($urandom())};
			p = {$urandom(), $urandom()} & ~64'h3;
			src_v = {$urandom(), $urandom()};
			step(w, p, 1'b1);
			chk("opcode", o_opcode, w[31:26]);
			chk("src", o_src, w[25:21]);
			chk("tgt", o_tgt, w[20:16]);
			chk("dst", o_dst, w[15:11]);
			chk("shamt", o_sh, w[10:6]);
			chk("func", o_func, w[5:0]);
			chk("imm", o_imm, {{16{w[15]}}, w[15:0]});
			chk("jump", o_jump_target, {p[63:28], w[25:0], 2'b00});
			chk("fmt", o_fmt, fmt_exp(opc));
			chk("reg_imm_class", o_reg_imm_cls, opc == IDC_OPC_REG_IMMEDIATE_CLASS);
			chk("valid", o_valid, 1'b1);
		end
		src_v = '0;
		cop(mk(IDC_OPC_SYSCTL, IDC_CSUB_MF, 6'h0), 1'b1, 4'h1, 1'b0);
		chk("kind", o_cp_kind, IDC_CK_MOVE);
		cop(mk(IDC_OPC_SYSCTL, IDC_CSUB_CT, 6'h0), 1'b1, 4'h1, 1'b0);
		chk("ctrl", o_ctrl, 1'b1);
		cop(mk(IDC_OPC_COP1, 5'h10, 6'h0), 1'b1, 4'h0, 1'b1);
		chk("unum", o_unum, 2'h1);
		wr(1'b0, 1'b0, 1'b1);
		chk("fpu_en", o_fpu_en, 1'b0);
		cop(mk(IDC_OPC_SYSCTL, IDC_CSUB_MT, 6'h0), 1'b0, 4'h0, 1'b1);
		chk("unum", o_unum, 2'h0);
		wr(1'b1, 1'b0, 1'b1);
		chk("fpu_en", o_fpu_en, 1'b1);
		cop(mk(IDC_OPC_COP1, 5'h10, 6'h0), 1'b1, 4'h2, 1'b0);
		cop(mk(IDC_OPC_FPU_EXTENDED_SPACE, 5'h0, 6'h20), 1'b1, 4'h2, 1'b0);
		chk("nonstd", o_nonstd, 1'b1);
		cop(mk(IDC_OPC_COP1, 5'h10, IDC_FN_RSQRT), 1'b1, 4'h2, 1'b0);
		chk("nonstd", o_nonstd, 1'b1);
		cop(mk(IDC_OPC_COP2, IDC_CSUB_MF, 6'h0), 1'b1, 4'h4, 1'b0);
		cop(mk(IDC_OPC_LWC1, 5'h0, 6'h0), 1'b1, 4'h2, 1'b0);
		chk("kind", o_cp_kind, IDC_CK_MEM);
		// earlier release mode: slot 3 space stays on its own slot
		@(posedge i_clk) i_ext_space <= 1'b0;
		cop(mk(IDC_OPC_FPU_EXTENDED_SPACE, 5'h0, 6'h20), 1'b1, 4'h8, 1'b0);
		chk("kind", o_cp_kind, IDC_CK_COMPUTE);
		for (int v = 1; v >= 0; v--) begin
			wr(1'b1, 1'b1, v[0]);
			chk("width", o_width, v[0]);
		end
		step(32'h0, 64'h2, 1'b1);
		chk("align", o_align, 1'b1);
		src_v = 64'h1_0000_0000;
		step(32'h20, 64'h0, 1'b1);
		chk("undef", o_undef, 1'b1);
		@(posedge i_clk);
		stall <= 4'h1;
		i_word <= mk(IDC_OPC_SYSCTL, IDC_CSUB_MF, 6'h0);
		#1;
		chk("ready", o_ready, 1'b0);
		@(posedge i_clk);
		#1;
		chk("valid", o_valid, 1'b0);
		finish_test();
	end
endmodule // cpu_instr_decode_coproc_dispatch_bench
